// *** shared/cev_regs.vh ***
`ifndef CEV_REGS_VH
`define CEV_REGS_VH
// register offsets (byte addresses)
`define CEV_OFF_STATUS 8'h00
`define CEV_OFF_PC 8'h04
`define CEV_OFF_SSP 8'h08
`define CEV_OFF_VECTOR_BASE_ADDRESS 8'h0C
`define CEV_OFF_CMD 8'h10
`define CEV_OFF_STATE 8'h14
`define CEV_OFF_DRET_PC 8'h18
`define CEV_OFF_DRET_SR 8'h1C
`define CEV_OFF_STK_ADDR 8'h20
`define CEV_OFF_STK_DATA 8'h24
// status register field positions
`define CEV_SR_I0M 0
`define CEV_SR_I1M 1
`define CEV_SR_I2M 2
`define CEV_SR_I3M 3
`define CEV_SR_EM 4
`define CEV_SR_GM 5
`define CEV_SR_DM 6
`define CEV_SR_D 7
`define CEV_SR_MODE_LSB 8
`define CEV_SR_MODE_MSB 10
// reset values
`define CEV_SR_RESET 32'h0000_0020
`define CEV_SSP_RESET 32'h0000_0400
`define CEV_VECTOR_BASE_ADDRESS_RESET 32'h0000_0000
`define CEV_PC_RESET 32'h8000_0000
// handler offsets
`define CEV_VEC_UNREC 32'h0000_0000
`define CEV_VEC_MHIT 32'h0000_0004
`define CEV_VEC_BUSD 32'h0000_0008
`define CEV_VEC_BUSI 32'h0000_000C
`define CEV_VEC_NMI 32'h0000_0010
`define CEV_VEC_IADDR 32'h0000_0014
`define CEV_VEC_SCALL 32'h0000_0100
`define CEV_VEC_DEBUG 32'h0000_001C
// mode encodings
`define CEV_MODE_APP 3'h0
`define CEV_MODE_SUP 3'h1
`define CEV_MODE_IRQ_LEVEL_ZERO 3'h2
`define CEV_MODE_EXC 3'h6
`define CEV_MODE_NMI 3'h7
// command codes
`define CEV_CMD_RETE 4'h1
`define CEV_CMD_SCALL 4'h2
`define CEV_CMD_RETS 4'h3
`define CEV_CMD_RETD 4'h4
`define CEV_CMD_DMB 4'h5
`define CEV_CMD_IADDR 4'h6
`endif

// *** src/cev_event_unit.v ***
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cev_regs.vh"
// Summary of operation
// RULE1: non-call, non-debug events are accepted as one uninterruptible sequence.
// RULE2: masked event levels are never accepted.
// RULE3: NMI, unrecoverable, multiple hit and bus errors ignore every mask.
// RULE4: acceptance sets mask bits of equal and lower priority sources.
// RULE5: sources hold requests until cleared; unlatched here.
// RULE6: acceptance pushes status and program counter to the system stack.
// RULE7: interrupt levels also push R8-R12 and the link register.
// RULE8: accepted exceptions set both exception and global masks.
// RULE9: each exception has its own handler address.
// RULE10: after stacking set mode, bank, then load handler address.
// RULE11: event return pops status and program counter.
// RULE12: returning from interrupt levels also pops R8-R12 and link register.
// RULE13: priority only orders simultaneous events; unmasked pending events still taken.
// RULE14: supervisor call and its return use the system stack.
// RULE15: debug request enters debug mode unless debug mask set.
// RULE16: debug entry sets debug flag and jumps to debug handler.
// RULE17: debug mode saves context in dedicated return registers.
// RULE18: debug return leaves debug mode and restores prior context.
// RULE19: stacking always uses the system stack pointer.
// RULE20: a request still high after event return is taken again.
// RULE21: sources drop requests a few cycles after the clearing access.
// RULE22: memory barrier stalls until the request is deasserted.
// RULE23: interrupt handler is vector base ORed with 14-bit autovector offset.
// RULE24: priority: NMI, level three, two, one, zero lowest.
module cev_event_unit #(
    parameter STACK_WORDS = 64
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // event sources
    input wire irq_level_zero,
    input wire irq_level_one,
    input wire irq_level_two,
    input wire irq_level_three,
    input wire irq_nmi,
    input wire [13:0] autovector_offset,
    input wire exc_unrecoverable,
    input wire exc_multi_hit,
    input wire exc_bus_data,
    input wire exc_bus_instr,
    input wire debug_request,
    // register file side (R8-R12, link register) for stacking
    input wire [31:0] gpr_rd_data,
    output reg [2:0] gpr_sel,
    output reg gpr_wr,
    output reg [31:0] gpr_wr_data,
    // core status
    output wire [2:0] bank_sel,
    output reg event_ack,
    output wire busy,
    output wire barrier_stall
);

    localparam ST_IDLE = 3'd0;
    localparam ST_PUSH = 3'd1;
    localparam ST_JUMP = 3'd2;
    localparam ST_POP = 3'd3;
    localparam ST_DONE = 3'd4;
    localparam ST_BAR = 3'd5;
    // stack index width follows the stack depth so addresses wrap inside it
    localparam AW = $clog2(STACK_WORDS);

    reg rst_s1_reg, rst_s2_reg;
    wire rst_n = rst_s2_reg;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    reg [31:0] stack_mem [0:STACK_WORDS-1];
    reg [31:0] sr_reg, pc_reg, ssp_reg, vector_base_address_reg, dret_pc_reg, dret_sr_reg;
    reg [31:0] stk_addr_reg;
    reg [2:0] state_reg;
    reg [3:0] step_reg;
    reg ints_reg;
    reg [3:0] cmd_reg;
    reg [31:0] vec_reg, sr_new_reg;
    reg [2:0] mode_new_reg;
    reg d_act_reg, d_wr_reg;
    reg [7:0] d_addr_reg;

    wire [2:0] cur_mode = sr_reg[`CEV_SR_MODE_MSB:`CEV_SR_MODE_LSB];
    wire gm = sr_reg[`CEV_SR_GM];
    wire em = sr_reg[`CEV_SR_EM];
    wire dbg = sr_reg[`CEV_SR_D];
    wire crit = exc_unrecoverable | exc_multi_hit | exc_bus_data | exc_bus_instr; // RULE3
    wire ok3 = irq_level_three & ~gm & ~sr_reg[`CEV_SR_I3M]; // RULE2
    wire ok2 = irq_level_two & ~gm & ~sr_reg[`CEV_SR_I2M]; // RULE2
    wire ok1 = irq_level_one & ~gm & ~sr_reg[`CEV_SR_I1M]; // RULE2
    wire ok0 = irq_level_zero & ~gm & ~sr_reg[`CEV_SR_I0M]; // RULE2
    wire dbg_ok = debug_request & ~sr_reg[`CEV_SR_DM] & ~dbg; // RULE15
    wire irq_any = irq_level_zero | irq_level_one | irq_level_two | irq_level_three;
    wire take = ~dbg & (crit | irq_nmi | ok3 | ok2 | ok1 | ok0); // RULE13

    assign bank_sel = cur_mode; // RULE10
    assign busy = (state_reg != ST_IDLE);
    assign barrier_stall = (state_reg == ST_BAR);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // handler, new status and mode for the winning event
    reg [31:0] sel_vec, sel_sr;
    reg [2:0] sel_mode;
    reg sel_ints;
    always @* begin
        sel_vec = vector_base_address_reg | `CEV_VEC_NMI;
        sel_sr = sr_reg;
        sel_mode = `CEV_MODE_NMI;
        sel_ints = 1'b0;
        // sources above an interrupt also mask every interrupt level
        if (crit) begin
            sel_mode = `CEV_MODE_EXC;
            sel_sr = sr_reg | 32'h0000_003F; // RULE4 RULE8
            if (exc_unrecoverable)
                sel_vec = vector_base_address_reg | `CEV_VEC_UNREC; // RULE9
            else if (exc_multi_hit)
                sel_vec = vector_base_address_reg | `CEV_VEC_MHIT; // RULE9
            else if (exc_bus_data)
                sel_vec = vector_base_address_reg | `CEV_VEC_BUSD; // RULE9
            else
                sel_vec = vector_base_address_reg | `CEV_VEC_BUSI; // RULE9
        end else if (irq_nmi) begin // RULE24
            sel_sr = sr_reg | 32'h0000_003F; // RULE4
        end else begin
            sel_ints = 1'b1; // RULE7
            sel_vec = vector_base_address_reg | {18'h00000, autovector_offset}; // RULE23
            if (ok3) begin
                sel_mode = `CEV_MODE_IRQ_LEVEL_ZERO + 3'h3;
                sel_sr = sr_reg | 32'h0000_000F; // RULE4
            end else if (ok2) begin
                sel_mode = `CEV_MODE_IRQ_LEVEL_ZERO + 3'h2;
                sel_sr = sr_reg | 32'h0000_0007; // RULE4
            end else if (ok1) begin
                sel_mode = `CEV_MODE_IRQ_LEVEL_ZERO + 3'h1;
                sel_sr = sr_reg | 32'h0000_0003; // RULE4
            end else begin
                sel_mode = `CEV_MODE_IRQ_LEVEL_ZERO;
                sel_sr = sr_reg | 32'h0000_0001; // RULE4
            end
        end
    end

    wire ret_ints = (cur_mode >= `CEV_MODE_IRQ_LEVEL_ZERO) && (cur_mode <= `CEV_MODE_IRQ_LEVEL_ZERO + 3'h3);
    wire [2:0] nsteps = ints_reg ? 3'd7 : 3'd1;
    wire [31:0] ssp_dec = ssp_reg - 32'h0000_0004;
    wire [AW-1:0] widx = ssp_dec[AW+1:2];
    wire [AW-1:0] ridx = ssp_reg[AW+1:2];

    // push order: pc, sr, then R8 up to R12 and the link register
    // pops come back in reverse, so a restore names its target from the top down
    always @* begin
        gpr_sel = 3'd0;
        if (state_reg == ST_PUSH && step_reg >= 4'd2)
            gpr_sel = step_reg[2:0] - 3'd2;
        else if (gpr_wr)
            gpr_sel = 3'd6 - step_reg[2:0]; // RULE12
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_reg <= `CEV_SR_RESET;
            pc_reg <= `CEV_PC_RESET;
            ssp_reg <= `CEV_SSP_RESET;
            vector_base_address_reg <= `CEV_VECTOR_BASE_ADDRESS_RESET;
            dret_pc_reg <= 32'h0000_0000;
            dret_sr_reg <= 32'h0000_0000;
            stk_addr_reg <= 32'h0000_0000;
            state_reg <= ST_IDLE;
            step_reg <= 4'h0;
            ints_reg <= 1'b0;
            cmd_reg <= 4'h0;
            vec_reg <= 32'h0000_0000;
            sr_new_reg <= 32'h0000_0000;
            mode_new_reg <= 3'h0;
            d_act_reg <= 1'b0;
            d_wr_reg <= 1'b0;
            d_addr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            gpr_wr <= 1'b0;
            gpr_wr_data <= 32'h0000_0000;
            event_ack <= 1'b0;
        end else begin
            event_ack <= 1'b0;
            gpr_wr <= 1'b0;
            cmd_reg <= 4'h0;
            d_act_reg <= hsel & hready & htrans[1];
            d_wr_reg <= hwrite;
            d_addr_reg <= haddr[7:0];
            if (hsel & hready & htrans[1] & ~hwrite) begin
                case (haddr[7:0])
                    `CEV_OFF_STATUS: hrdata <= sr_reg;
                    `CEV_OFF_PC: hrdata <= pc_reg;
                    `CEV_OFF_SSP: hrdata <= ssp_reg;
                    `CEV_OFF_VECTOR_BASE_ADDRESS: hrdata <= vector_base_address_reg;
                    `CEV_OFF_STATE: hrdata <= {26'h0, irq_any, busy, 1'b0, state_reg};
                    `CEV_OFF_DRET_PC: hrdata <= dret_pc_reg;
                    `CEV_OFF_DRET_SR: hrdata <= dret_sr_reg;
                    `CEV_OFF_STK_ADDR: hrdata <= stk_addr_reg;
                    `CEV_OFF_STK_DATA: hrdata <= stack_mem[stk_addr_reg[AW+1:2]];
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
            // status, PC and SSP writes are dropped, not deferred, while the sequencer is out of idle
            if (d_act_reg & d_wr_reg) begin
                case (d_addr_reg)
                    `CEV_OFF_STATUS: if (state_reg == ST_IDLE) sr_reg <= hwdata;
                    `CEV_OFF_PC: if (state_reg == ST_IDLE) pc_reg <= hwdata;
                    `CEV_OFF_SSP: if (state_reg == ST_IDLE) ssp_reg <= hwdata;
                    `CEV_OFF_VECTOR_BASE_ADDRESS: vector_base_address_reg <= hwdata;
                    `CEV_OFF_CMD: cmd_reg <= hwdata[3:0];
                    `CEV_OFF_STK_ADDR: stk_addr_reg <= hwdata;
                    default: ;
                endcase
            end
            case (state_reg)
                ST_IDLE: begin
                    if (dbg_ok) begin
                        dret_pc_reg <= pc_reg; // RULE17
                        dret_sr_reg <= sr_reg; // RULE17
                        sr_reg[`CEV_SR_D] <= 1'b1; // RULE16
                        sr_reg[`CEV_SR_MODE_MSB:`CEV_SR_MODE_LSB] <= `CEV_MODE_EXC; // RULE17
                        pc_reg <= vector_base_address_reg | `CEV_VEC_DEBUG; // RULE16
                        event_ack <= 1'b1;
                    end else if (take) begin // RULE1
                        vec_reg <= sel_vec;
                        sr_new_reg <= sel_sr;
                        mode_new_reg <= sel_mode;
                        ints_reg <= sel_ints;
                        step_reg <= 4'h0;
                        state_reg <= ST_PUSH;
                        event_ack <= 1'b1;
                    end else if (cmd_reg == `CEV_CMD_SCALL || cmd_reg == `CEV_CMD_IADDR) begin
                        vec_reg <= vector_base_address_reg | ((cmd_reg == `CEV_CMD_SCALL) ?
                            `CEV_VEC_SCALL : `CEV_VEC_IADDR); // RULE9 RULE14
                        sr_new_reg <= (cmd_reg == `CEV_CMD_SCALL) ? sr_reg :
                            (sr_reg | 32'h0000_0030); // RULE8
                        mode_new_reg <= (cmd_reg == `CEV_CMD_SCALL) ?
                            `CEV_MODE_SUP : `CEV_MODE_EXC;
                        ints_reg <= 1'b0;
                        step_reg <= 4'h0;
                        state_reg <= ST_PUSH;
                    end else if (cmd_reg == `CEV_CMD_RETE || cmd_reg == `CEV_CMD_RETS) begin
                        ints_reg <= (cmd_reg == `CEV_CMD_RETE) & ret_ints; // RULE12
                        step_reg <= 4'h0;
                        state_reg <= ST_POP;
                    end else if (cmd_reg == `CEV_CMD_RETD && dbg) begin
                        pc_reg <= dret_pc_reg; // RULE18
                        sr_reg <= dret_sr_reg; // RULE18
                    end else if (cmd_reg == `CEV_CMD_DMB && irq_any) begin
                        state_reg <= ST_BAR; // RULE22
                    end
                end
                ST_PUSH: begin
                    // one word per cycle onto the system stack
                    ssp_reg <= ssp_dec; // RULE19
                    if (step_reg == 4'h0)
                        stack_mem[widx] <= pc_reg; // RULE6
                    else if (step_reg == 4'h1)
                        stack_mem[widx] <= sr_reg; // RULE6
                    else
                        stack_mem[widx] <= gpr_rd_data; // RULE7
                    step_reg <= step_reg + 4'h1;
                    if (step_reg[2:0] == nsteps)
                        state_reg <= ST_JUMP;
                end
                ST_JUMP: begin
                    sr_reg <= sr_new_reg;
                    sr_reg[`CEV_SR_MODE_MSB:`CEV_SR_MODE_LSB] <= mode_new_reg; // RULE10
                    pc_reg <= vec_reg; // RULE10
                    state_reg <= ST_IDLE;
                end
                ST_POP: begin
                    // reverse of push: link register, R12..R8, then sr, pc
                    ssp_reg <= ssp_reg + 32'h0000_0004; // RULE19
                    if (ints_reg && step_reg < 4'h6) begin
                        gpr_wr <= 1'b1; // RULE12
                        gpr_wr_data <= stack_mem[ridx];
                    end else if (step_reg == (ints_reg ? 4'h6 : 4'h0)) begin
                        sr_reg <= stack_mem[ridx]; // RULE11
                    end else begin
                        pc_reg <= stack_mem[ridx]; // RULE11
                        state_reg <= ST_DONE;
                    end
                    step_reg <= step_reg + 4'h1;
                end
                ST_DONE: begin
                    // a request still high is arbitrated again from idle
                    state_reg <= ST_IDLE; // RULE20
                end
                ST_BAR: begin
                    if (!irq_any)
                        state_reg <= ST_IDLE; // RULE22
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** tb/cev_irq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module cev_irq_ctrl #(
    parameter int CLR_DELAY = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bench control
    input wire logic [4:0] raise,
    input wire logic clr,
    input wire logic [13:0] vec,
    // requests toward the core
    output logic [4:0] irq,
    output logic [13:0] offset
);
    int dly;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 5'h00;
            offset <= 14'h0000;
            dly <= 0;
        end else begin
            // only a clear access drops a request, never the acceptance itself
            if (raise != 5'h00) begin
                irq <= irq | raise;
                offset <= vec;
            end
            if (clr)
                dly <= CLR_DELAY;
            else if (dly > 0)
                dly <= dly - 1;
            if (dly == 1) begin
                irq <= 5'h00;
                offset <= ~offset;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/cev_event_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module cev_event_monitor #(
    parameter STACK_WORDS = 64
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // bus answer
    input wire hreadyout,
    input wire hresp,
    // requests
    input wire irq_level_zero,
    input wire irq_level_one,
    input wire irq_level_two,
    input wire irq_level_three,
    input wire irq_nmi,
    input wire debug_request,
    // core side
    input wire [2:0] gpr_sel,
    input wire gpr_wr,
    input wire event_ack,
    input wire busy,
    input wire barrier_stall
);
    // a sequencer that never returns to idle would block every later event
    logic [4:0] seq_cnt;
    logic irq_any;
    assign irq_any = irq_level_zero | irq_level_one | irq_level_two | irq_level_three | irq_nmi;
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            seq_cnt <= 5'h00;
        else if (busy && !barrier_stall && seq_cnt != 5'h1F)
            seq_cnt <= seq_cnt + 5'h01;
        else if (!busy || barrier_stall)
            seq_cnt <= 5'h00;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    ack_single_a: assert property (event_ack |=> !event_ack [*8])
        else $error("second acceptance inside a stacking sequence");
    ack_busy_a: assert property (event_ack && !debug_request |-> ##[0:1] busy)
        else $error("acceptance without sequencer activity");
    ack_done_a: assert property (event_ack |-> ##[1:20] !busy)
        else $error("entry sequence did not complete");
    seq_bound_a: assert property (seq_cnt != 5'h1F)
        else $error("sequencer stuck busy");
    restore_sel_a: assert property (gpr_wr |-> gpr_sel <= 3'h5 && busy)
        else $error("restore write outside a pop or to a bad register");
    barrier_hold_a: assert property (barrier_stall && irq_any |=> barrier_stall)
        else $error("barrier released while a request is up");
    barrier_free_a: assert property (barrier_stall && !irq_any |-> ##[1:3] !barrier_stall)
        else $error("barrier not released after request dropped");
endmodule
bind cev_event_unit cev_event_monitor #(.STACK_WORDS(STACK_WORDS)) cev_event_monitor_i (
    .clk(clk), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp),
    .irq_level_zero(irq_level_zero), .irq_level_one(irq_level_one),
    .irq_level_two(irq_level_two), .irq_level_three(irq_level_three), .irq_nmi(irq_nmi),
    .debug_request(debug_request),
    .gpr_sel(gpr_sel), .gpr_wr(gpr_wr), .event_ack(event_ack), .busy(busy),
    .barrier_stall(barrier_stall)
);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cev_regs.vh"
module tb;
    logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp, dbg, clr;
    logic gpr_wr, event_ack, busy, barrier_stall;
    logic [31:0] haddr, hwdata, hrdata, gpr_wr_data, gpr_rd_data;
    logic [1:0] htrans;
    logic [2:0] hsize, gpr_sel, bank_sel;
    logic [4:0] irq, raise;
    logic [3:0] exc;
    logic [13:0] av;
    int n_errors = 0;
    int checks_done = 0;
    int n_ack = 0;
    int n_rst = 0;
    localparam logic [31:0] VECTOR_BASE_ADDRESS = 32'h0001_0000;
    assign hready = hreadyout;
    // stacked registers carry distinct values so a swapped restore shows
    assign gpr_rd_data = 32'hA0 + {29'h0, gpr_sel};
    cev_event_unit cev_event_unit_i (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_level_zero(irq[0]),
        .irq_level_one(irq[1]), .irq_level_two(irq[2]), .irq_level_three(irq[3]),
        .irq_nmi(irq[4]), .autovector_offset(av), .exc_unrecoverable(exc[0]),
        .exc_multi_hit(exc[1]), .exc_bus_data(exc[2]), .exc_bus_instr(exc[3]),
        .debug_request(dbg), .gpr_rd_data(gpr_rd_data), .gpr_sel(gpr_sel), .gpr_wr(gpr_wr),
        .gpr_wr_data(gpr_wr_data), .bank_sel(bank_sel), .event_ack(event_ack), .busy(busy),
        .barrier_stall(barrier_stall));
    cev_irq_ctrl #(.CLR_DELAY(12)) cev_irq_ctrl_i (.clk(clk), .resetn(resetn),
        .raise(raise), .clr(clr), .vec(14'h2A5C), .irq(irq), .offset(av));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task end_sim;
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic idle;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
        chk({31'h0, busy}, 32'h0);
    endtask
    task automatic cmd(input logic [3:0] c);
        wr(`CEV_OFF_CMD, {28'h0, c});
        idle();
    endtask
    task automatic wait_ack;
        int k;
        k = n_ack;
        for (int i = 0; i < 100 && n_ack == k; i++) @(posedge clk);
        chk(n_ack - k, 1);
    endtask
    always @(negedge clk) begin
        if (event_ack === 1'b1)
            n_ack++;
        if (gpr_wr === 1'b1) begin
            n_rst++;
            chk(gpr_wr_data, 32'hA0 + {29'h0, gpr_sel});
        end
    end
    task automatic t_irq;
        wr(`CEV_OFF_VECTOR_BASE_ADDRESS, VECTOR_BASE_ADDRESS);
        raise <= 5'h01;
        @(posedge clk);
        raise <= 5'h00;
        repeat (30) @(posedge clk);
        chk(n_ack, 0);
        wr(`CEV_OFF_STATUS, 32'h0);
        wait_ack();
        idle();
        rd(`CEV_OFF_PC, VECTOR_BASE_ADDRESS | 32'h2A5C);
        rd(`CEV_OFF_SSP, 32'h3E0);
        rd(`CEV_OFF_STATUS, 32'h201);
        wr(`CEV_OFF_CMD, {28'h0, `CEV_CMD_RETE});
        wait_ack();
        idle();
        chk(n_rst, 6);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wr(`CEV_OFF_CMD, {28'h0, `CEV_CMD_DMB});
        repeat (4) @(posedge clk);
        chk({31'h0, barrier_stall}, 32'h1);
        for (int i = 0; i < 100 && barrier_stall !== 1'b0; i++) @(posedge clk);
        chk({27'h0, irq}, 32'h0);
        cmd(`CEV_CMD_RETE);
        rd(`CEV_OFF_PC, `CEV_PC_RESET);
        rd(`CEV_OFF_SSP, `CEV_SSP_RESET);
        rd(`CEV_OFF_STATUS, 32'h0);
        chk(n_rst, 12);
    endtask
    task automatic t_scall;
        logic [31:0] v;
        cmd(`CEV_CMD_SCALL);
        rd(`CEV_OFF_PC, VECTOR_BASE_ADDRESS | `CEV_VEC_SCALL);
        rd(`CEV_OFF_SSP, 32'h3F8);
        bus(1'b0, `CEV_OFF_STATUS, 32'h0, v);
        chk({29'h0, v[10:8]}, {29'h0, `CEV_MODE_SUP});
        cmd(`CEV_CMD_RETS);
        rd(`CEV_OFF_PC, `CEV_PC_RESET);
        rd(`CEV_OFF_SSP, `CEV_SSP_RESET);
    endtask
    task automatic t_exc;
        logic [31:0] vecs [4];
        vecs = '{`CEV_VEC_UNREC, `CEV_VEC_MHIT, `CEV_VEC_BUSD, `CEV_VEC_BUSI};
        for (int i = 0; i < 4; i++) begin
            wr(`CEV_OFF_STATUS, 32'h3F);
            exc <= 4'h1 << i;
            wait_ack();
            exc <= 4'h0;
            idle();
            rd(`CEV_OFF_PC, VECTOR_BASE_ADDRESS | vecs[i]);
            rd(`CEV_OFF_STATUS, 32'h63F);
            rd(`CEV_OFF_SSP, 32'h3F8);
            cmd(`CEV_CMD_RETE);
            rd(`CEV_OFF_STATUS, 32'h3F);
        end
        cmd(`CEV_CMD_IADDR);
        rd(`CEV_OFF_PC, VECTOR_BASE_ADDRESS | `CEV_VEC_IADDR);
        rd(`CEV_OFF_STATUS, 32'h63F);
        cmd(`CEV_CMD_RETE);
        rd(`CEV_OFF_STATUS, 32'h3F);
    endtask
    task automatic t_debug;
        logic [31:0] v;
        wr(`CEV_OFF_STATUS, 32'h40);
        dbg <= 1'b1;
        repeat (20) @(posedge clk);
        rd(`CEV_OFF_STATUS, 32'h40);
        wr(`CEV_OFF_STATUS, 32'h0);
        idle();
        bus(1'b0, `CEV_OFF_STATUS, 32'h0, v);
        chk({31'h0, v[`CEV_SR_D]}, 32'h1);
        rd(`CEV_OFF_PC, VECTOR_BASE_ADDRESS | `CEV_VEC_DEBUG);
        rd(`CEV_OFF_SSP, `CEV_SSP_RESET);
        rd(`CEV_OFF_DRET_PC, `CEV_PC_RESET);
        dbg <= 1'b0;
        cmd(`CEV_CMD_RETD);
        rd(`CEV_OFF_STATUS, 32'h0);
        rd(`CEV_OFF_PC, `CEV_PC_RESET);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (8000) @(posedge clk);
        n_errors++;
        end_sim();
    end
    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        dbg = 1'b0;
        clr = 1'b0;
        raise = 5'h00;
        exc = 4'h0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`CEV_OFF_STATUS, `CEV_SR_RESET);
        rd(`CEV_OFF_SSP, `CEV_SSP_RESET);
        rd(8'h40, 32'h0);
        t_irq();
        t_scall();
        t_exc();
        t_debug();
        end_sim();
    end
endmodule
`default_nettype wire
